/* File: verilog/incskip_or_movlit_pkg.sv */
// shared constants, opcode patterns and decode types for the executor
`default_nettype none
package incskip_or_movlit_pkg;

	// datapath widths
	localparam int DATA_W = 8; // accumulator and file register width
	localparam int INSTR_W = 14; // program word width
	localparam int FADDR_W = 7; // file address width
	localparam int FILE_DEPTH = 128; // number of file registers
	localparam int PC_W = 10; // fetch address width

	// instruction cycle timing
	localparam int OSC_PER_CYCLE = 4; // oscillator periods per cycle
	localparam int PHASE_W = 2; // width of the phase counter

	// field positions inside the program word
	localparam int OPC6_MSB = 13; // top of six-bit opcode field
	localparam int OPC6_LSB = 8; // bottom of six-bit opcode field
	localparam int OPC4_LSB = 10; // bottom of four-bit opcode field
	localparam int DEST_BIT = 7; // destination select bit
	localparam int FADDR_MSB = 6; // top of file address field
	localparam int LIT_MSB = 7; // top of literal field

	// opcode patterns
	localparam logic [5:0] OPC_INC_SKIP = 6'h0F; // 00 1111
	localparam logic [5:0] OPC_OR_FILE = 6'h04; // 00 0100
	localparam logic [5:0] OPC_OR_LIT = 6'h38; // 11 1000
	localparam logic [3:0] OPC_LOAD_LIT = 4'hC; // 11 00xx

	// reset and arithmetic values
	localparam logic [DATA_W-1:0] ACC_RST = 8'h00; // accumulator at reset
	localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00; // zero test value
	localparam logic [DATA_W-1:0] DATA_ONE = 8'h01; // increment step
	localparam logic [PC_W-1:0] PC_RST = 10'h000; // first fetch address
	localparam logic [PC_W-1:0] PC_STEP = 10'h001; // fetch advance
	localparam logic [INSTR_W-1:0] INSTR_NOP = 14'h0000; // idle word

	// instruction kinds this block executes
	typedef enum logic [2:0] {
		OP_NOP,
		OP_INC_SKIP,
		OP_OR_FILE,
		OP_OR_LIT,
		OP_LOAD_LIT
	} op_kind_t;

	// decoded instruction carried between decode and execute
	typedef struct packed {
		op_kind_t kind; // what to do
		logic dest_file; // 1: result back to file register
		logic [FADDR_W-1:0] faddr; // file register operand
		logic [DATA_W-1:0] lit; // literal operand
	} decoded_t;

	// external file register write port
	typedef struct packed {
		logic en; // write strobe
		logic [FADDR_W-1:0] addr; // register to write
		logic [DATA_W-1:0] data; // value to write
	} file_wr_t;

endpackage
`default_nettype wire

/* File: verilog/cycle_phase_seq.sv */
// four-phase sequencer marking the end of each instruction cycle
`timescale 1ns/1ps
`default_nettype none

module cycle_phase_seq (
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	output logic cycle_end_o
);

	// one state per oscillator period of the instruction cycle
	typedef enum logic [incskip_or_movlit_pkg::PHASE_W-1:0] {
		PH_Q1,
		PH_Q2,
		PH_Q3,
		PH_Q4
	} phase_t;

	phase_t phase_ff; // current phase
	phase_t nxt_phase; // phase for the next period
	logic nxt_cycle_end; // high while heading into the last phase

	// phases step round in a fixed ring
	always_comb begin
		case (phase_ff)
			PH_Q1: nxt_phase = PH_Q2;
			PH_Q2: nxt_phase = PH_Q3;
			PH_Q3: nxt_phase = PH_Q4;
			PH_Q4: nxt_phase = PH_Q1;
			default: nxt_phase = PH_Q1;
		endcase
	end

	// registered so the strobe is a clean flop output
	assign nxt_cycle_end = (nxt_phase == PH_Q4);

	// phase register and end-of-cycle strobe
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			phase_ff <= PH_Q1;
			cycle_end_o <= 1'b0;
		end else begin
			phase_ff <= nxt_phase;
			cycle_end_o <= nxt_cycle_end;
		end
	end

endmodule

`default_nettype wire

/* File: verilog/incskip_or_movlit_exec.sv */
// fetch, decode and execute of increment-skip, or and literal-load words
`timescale 1ns/1ps
`default_nettype none

module incskip_or_movlit_exec (
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	output logic [incskip_or_movlit_pkg::PC_W-1:0] pm_addr_o,
	input wire logic [incskip_or_movlit_pkg::INSTR_W-1:0] pm_data_i,
	input wire logic file_wr_i,
	input wire logic [incskip_or_movlit_pkg::FADDR_W-1:0] file_wr_addr_i,
	input wire logic [incskip_or_movlit_pkg::DATA_W-1:0] file_wr_data_i,
	input wire logic [incskip_or_movlit_pkg::FADDR_W-1:0] file_rd_addr_i,
	output logic [incskip_or_movlit_pkg::DATA_W-1:0] file_rd_data_o,
	output logic [incskip_or_movlit_pkg::DATA_W-1:0] acc_o,
	output logic zero_flag_o,
	output logic exec_valid_o,
	output logic exec_nop_o
);

	// strobe high in the last period of each instruction cycle
	logic cycle_end;

	// pipeline state
	logic [incskip_or_movlit_pkg::INSTR_W-1:0] instr_ff; // word in execute
	logic squash_ff; // word in execute was discarded by a skip
	logic [incskip_or_movlit_pkg::PC_W-1:0] pc_ff; // next fetch address
	logic [incskip_or_movlit_pkg::DATA_W-1:0] acc_ff; // accumulator
	logic zero_ff; // zero flag

	// file register array, data only, so it carries no reset
	logic [incskip_or_movlit_pkg::DATA_W-1:0]
		file_mem [incskip_or_movlit_pkg::FILE_DEPTH];

	// host-side write bundled for the write mux
	incskip_or_movlit_pkg::file_wr_t host_wr;

	// decode wires
	logic [5:0] opc6; // six-bit opcode field
	logic [3:0] opc4; // four-bit opcode field, low pair ignored
	logic hit_inc; // pattern match, increment and skip
	logic hit_orf; // pattern match, or with file
	logic hit_orl; // pattern match, or with literal
	logic hit_ldl; // pattern match, load literal
	incskip_or_movlit_pkg::op_kind_t dec_kind; // kind before squash
	incskip_or_movlit_pkg::decoded_t dec; // full decode

	// execute wires
	logic exec_live; // an instruction actually executes this edge
	logic is_inc; // increment and skip executes
	logic is_orf; // or with file executes
	logic is_orl; // or with literal executes
	logic is_ldl; // literal load executes
	logic [incskip_or_movlit_pkg::DATA_W-1:0] fval; // file operand
	logic [incskip_or_movlit_pkg::DATA_W-1:0] inc_sum; // file plus one
	logic [incskip_or_movlit_pkg::DATA_W-1:0] orf_res; // acc or file
	logic [incskip_or_movlit_pkg::DATA_W-1:0] orl_res; // acc or literal
	logic [incskip_or_movlit_pkg::DATA_W-1:0] result; // selected result
	logic res_zero; // selected result is zero
	logic inc_zero; // increment wrapped to zero
	logic wr_acc; // result goes to accumulator
	logic wr_file; // result goes to file register

	// next values
	logic [incskip_or_movlit_pkg::DATA_W-1:0] nxt_acc;
	logic nxt_zero;
	logic nxt_squash;
	logic [incskip_or_movlit_pkg::INSTR_W-1:0] nxt_instr;
	logic [incskip_or_movlit_pkg::PC_W-1:0] nxt_pc;
	logic nxt_exec_nop;

	// one instruction cycle is four core clocks
	cycle_phase_seq u_phase (
		.core_clk_i(core_clk_i),
		.rst_b_i(rst_b_i),
		.cycle_end_o(cycle_end)
	);

	// opcode fields of the word now in execute
	assign opc6 = instr_ff[incskip_or_movlit_pkg::OPC6_MSB:
		incskip_or_movlit_pkg::OPC6_LSB];
	assign opc4 = instr_ff[incskip_or_movlit_pkg::OPC6_MSB:
		incskip_or_movlit_pkg::OPC4_LSB];

	// pattern matches
	assign hit_inc = (opc6 == incskip_or_movlit_pkg::OPC_INC_SKIP);
	assign hit_orf = (opc6 == incskip_or_movlit_pkg::OPC_OR_FILE);
	assign hit_orl = (opc6 == incskip_or_movlit_pkg::OPC_OR_LIT);
	// only the top four bits compared, so any value of the two don't-care bits loads
	assign hit_ldl = (opc4 == incskip_or_movlit_pkg::OPC_LOAD_LIT);

	// patterns do not overlap; anything else is idle here
	assign dec_kind = hit_inc ? incskip_or_movlit_pkg::OP_INC_SKIP :
		hit_orf ? incskip_or_movlit_pkg::OP_OR_FILE :
		hit_orl ? incskip_or_movlit_pkg::OP_OR_LIT :
		hit_ldl ? incskip_or_movlit_pkg::OP_LOAD_LIT :
		incskip_or_movlit_pkg::OP_NOP;

	// a squashed word decodes as a nop
	assign dec.kind = squash_ff ? incskip_or_movlit_pkg::OP_NOP : dec_kind;
	assign dec.dest_file = instr_ff[incskip_or_movlit_pkg::DEST_BIT];
	assign dec.faddr = instr_ff[incskip_or_movlit_pkg::FADDR_MSB:0];
	assign dec.lit = instr_ff[incskip_or_movlit_pkg::LIT_MSB:0];

	// execution happens once, at the close of the instruction cycle
	assign exec_live = cycle_end;
	assign is_inc = exec_live &&
		(dec.kind == incskip_or_movlit_pkg::OP_INC_SKIP);
	assign is_orf = exec_live &&
		(dec.kind == incskip_or_movlit_pkg::OP_OR_FILE);
	assign is_orl = exec_live &&
		(dec.kind == incskip_or_movlit_pkg::OP_OR_LIT);
	assign is_ldl = exec_live &&
		(dec.kind == incskip_or_movlit_pkg::OP_LOAD_LIT);

	// operand read, asynchronous from the array
	assign fval = file_mem[dec.faddr];

	// arithmetic; the sum wraps at eight bits by design
	assign inc_sum = fval + incskip_or_movlit_pkg::DATA_ONE;
	assign orf_res = acc_ff | fval;
	assign orl_res = acc_ff | dec.lit;

	// result select; literal load passes the literal straight through
	assign result = is_inc ? inc_sum :
		is_orf ? orf_res :
		is_orl ? orl_res :
		dec.lit;

	assign res_zero = (result == incskip_or_movlit_pkg::DATA_ZERO);
	assign inc_zero = (inc_sum == incskip_or_movlit_pkg::DATA_ZERO);

	// destination routing by the dest bit for the file forms
	assign wr_acc = ((is_inc || is_orf) && !dec.dest_file) ||
		is_orl || is_ldl;
	assign wr_file = (is_inc || is_orf) && dec.dest_file;

	// accumulator update
	assign nxt_acc = wr_acc ? result : acc_ff;

	// only the two or forms touch the zero flag
	assign nxt_zero = (is_orf || is_orl) ? res_zero : zero_ff;

	// a zero sum discards the already fetched word; nonzero lets it run
	assign nxt_squash = cycle_end ? (is_inc && inc_zero) : squash_ff;

	// fetch advances by one every cycle, skip or not, so a skip lands
	// two words on and a non-skip simply runs the next word
	assign nxt_pc = cycle_end ? (pc_ff + incskip_or_movlit_pkg::PC_STEP) :
		pc_ff;
	assign nxt_instr = cycle_end ? pm_data_i : instr_ff;

	// reported nop: squashed words and words outside this block's set
	assign nxt_exec_nop = cycle_end &&
		(dec.kind == incskip_or_movlit_pkg::OP_NOP);

	// host write port bundled
	assign host_wr.en = file_wr_i;
	assign host_wr.addr = file_wr_addr_i;
	assign host_wr.data = file_wr_data_i;

	// core state; the word in execute resets to an idle nop
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			instr_ff <= incskip_or_movlit_pkg::INSTR_NOP;
			squash_ff <= 1'b0;
			pc_ff <= incskip_or_movlit_pkg::PC_RST;
			acc_ff <= incskip_or_movlit_pkg::ACC_RST;
			zero_ff <= 1'b0;
		end else begin
			instr_ff <= nxt_instr;
			squash_ff <= nxt_squash;
			pc_ff <= nxt_pc;
			acc_ff <= nxt_acc;
			zero_ff <= nxt_zero;
		end
	end

	// file array write; the core wins a same-edge collision
	// because losing an instruction's result would corrupt the program
	always_ff @(posedge core_clk_i) begin
		if (wr_file) begin
			file_mem[dec.faddr] <= result;
		end else if (host_wr.en) begin
			file_mem[host_wr.addr] <= host_wr.data;
		end
	end

	// registered outputs
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pm_addr_o <= incskip_or_movlit_pkg::PC_RST;
			file_rd_data_o <= incskip_or_movlit_pkg::DATA_ZERO;
			acc_o <= incskip_or_movlit_pkg::ACC_RST;
			zero_flag_o <= 1'b0;
			exec_valid_o <= 1'b0;
			exec_nop_o <= 1'b0;
		end else begin
			pm_addr_o <= nxt_pc;
			file_rd_data_o <= file_mem[file_rd_addr_i];
			acc_o <= nxt_acc;
			zero_flag_o <= nxt_zero;
			exec_valid_o <= cycle_end;
			exec_nop_o <= nxt_exec_nop;
		end
	end

endmodule

`default_nettype wire

/* File: dv/exec_chk_asserts.sv */
// port-level assertions for the executor
`timescale 1ns/1ps
`default_nettype none
module exec_chk (
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	input wire logic [9:0] pm_addr_o,
	input wire logic [13:0] pm_data_i,
	input wire logic [7:0] acc_o,
	input wire logic zero_flag_o,
	input wire logic exec_valid_o,
	input wire logic exec_nop_o
);
	logic [13:0] word_ff; // word latched at the last fetch step
	logic run; // reported word really executed
	// follow the fetch: the word executes four cycles later
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i)
			word_ff <= 14'h0000;
		else if (pm_addr_o != $past(pm_addr_o))
			word_ff <= $past(pm_data_i);
	end
	assign run = exec_valid_o && !exec_nop_o;
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_b_i);
	// one result pulse every four clocks
	a_valid_spacing: assert property (
		exec_valid_o |=> !exec_valid_o [*3] ##1 exec_valid_o)
		else $error("valid pulses not four cycles apart");
	// fetch address only moves on the execute edge
	a_pc_hold: assert property (
		!exec_valid_o |-> $stable(pm_addr_o))
		else $error("fetch address moved mid cycle");
	a_pc_step: assert property (
		exec_valid_o |-> pm_addr_o == $past(pm_addr_o) + 10'h001)
		else $error("fetch address did not step by one");
	// architectural state only moves on the execute edge
	a_acc_quiet: assert property (
		!exec_valid_o |-> $stable(acc_o))
		else $error("accumulator changed off the execute edge");
	a_zero_quiet: assert property (
		!exec_valid_o |-> $stable(zero_flag_o))
		else $error("zero flag changed off the execute edge");
	// per-instruction results against the word that ran
	a_load_literal: assert property (
		run && word_ff[13:10] == 4'hC |->
		acc_o == word_ff[7:0] && $stable(zero_flag_o))
		else $error("literal load wrong");
	a_or_literal: assert property (
		run && word_ff[13:8] == 6'h38 |->
		acc_o == ($past(acc_o) | word_ff[7:0]) &&
		zero_flag_o == (acc_o == 8'h00))
		else $error("literal or wrong");
	a_or_file_acc: assert property (
		run && word_ff[13:7] == 7'h08 |->
		(acc_o & $past(acc_o)) == $past(acc_o) &&
		zero_flag_o == (acc_o == 8'h00))
		else $error("file or into accumulator wrong");
	a_file_dest: assert property (
		run && (word_ff[13:7] == 7'h09 || word_ff[13:7] == 7'h1F) |->
		$stable(acc_o))
		else $error("file destination touched accumulator");
	a_inc_flags: assert property (
		run && word_ff[13:8] == 6'h0F |-> $stable(zero_flag_o))
		else $error("increment changed zero flag");
	// a zero sum to the accumulator turns the next slot into a nop
	a_skip_next: assert property (
		run && word_ff[13:7] == 7'h1E && acc_o == 8'h00 |->
		##4 exec_valid_o && exec_nop_o)
		else $error("zero increment did not squash next word");
	c_skip: cover property (exec_nop_o && exec_valid_o);
	c_inc_file: cover property (run && word_ff[13:7] == 7'h1F);
	c_or_zero: cover property (
		run && word_ff[13:8] == 6'h38 && zero_flag_o);
endmodule
bind incskip_or_movlit_exec exec_chk u_chk (
	.core_clk_i(core_clk_i),
	.rst_b_i(rst_b_i),
	.pm_addr_o(pm_addr_o),
	.pm_data_i(pm_data_i),
	.acc_o(acc_o),
	.zero_flag_o(zero_flag_o),
	.exec_valid_o(exec_valid_o),
	.exec_nop_o(exec_nop_o)
);
`default_nettype wire

/* File: dv/pm_model.sv */
// program memory model answering the fetch address
`timescale 1ns/1ps
`default_nettype none
module pm_model (
	input wire logic [9:0] addr_i,
	output logic [13:0] data_o
);
	logic [13:0] mem [0:1023]; // words loaded by the bench
	// word follows the address at once, well inside the fetch slot
	assign data_o = mem[addr_i];
endmodule
`default_nettype wire

/* File: dv/incskip_or_movlit_exec_tb_top.sv */
// self-checking bench running short programs through the executor
`timescale 1ns/1ps
`default_nettype none
module incskip_or_movlit_exec_tb_top;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic we = 1'b0; // host file write strobe
	logic [6:0] wa = 7'h00;
	logic [7:0] wd = 8'h00;
	logic [6:0] ra = 7'h00;
	logic [9:0] pa;
	logic [13:0] pd;
	logic [7:0] rd, acc;
	logic z, v, n;
	int failures = 0;
	int checks = 0;
	always #2 clk = ~clk;
	incskip_or_movlit_exec u_dut (
		.core_clk_i(clk),
		.rst_b_i(rst_b),
		.pm_addr_o(pa),
		.pm_data_i(pd),
		.file_wr_i(we),
		.file_wr_addr_i(wa),
		.file_wr_data_i(wd),
		.file_rd_addr_i(ra),
		.file_rd_data_o(rd),
		.acc_o(acc),
		.zero_flag_o(z),
		.exec_valid_o(v),
		.exec_nop_o(n)
	);
	pm_model u_pm (.addr_i(pa), .data_o(pd));
	task results();
		if (failures == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task chk(input logic [7:0] s, input logic [7:0] e);
		checks++;
		if (s !== e) begin
			failures++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	// load eight words, rest idle, then reset for 12 cycles
	task go(input logic [13:0] w [8]);
		for (int i = 0; i < 1024; i++)
			u_pm.mem[i] = (i < 8) ? w[i] : 14'h0000;
		@(posedge clk);
		#1 rst_b = 1'b0;
		repeat (12) @(posedge clk);
		#1 rst_b = 1'b1;
	endtask
	task fwr(input logic [6:0] a, input logic [7:0] d);
		@(posedge clk);
		#1 we = 1'b1;
		wa = a;
		wd = d;
		@(posedge clk);
		#1 we = 1'b0;
	endtask
	// wait until word 0 is latched (fetch address 1), so the next
	// pulse is its result; at address 2 its pulse is already high, so step would miss it
	task sync();
		for (int i = 0; i < 20 && pa !== 10'h001; i++) begin
			@(posedge clk);
			#1;
		end
	endtask
	task step(input logic [7:0] ea, input logic ez, input logic en);
		int i;
		i = 0;
		do begin
			@(posedge clk);
			#1 i++;
		end while (v !== 1'b1 && i < 10);
		chk({7'h00, v}, 8'h01);
		chk(acc, ea);
		chk({7'h00, z}, {7'h00, ez});
		chk({7'h00, n}, {7'h00, en});
	endtask
	task rdchk(input logic [6:0] a, input logic [7:0] e);
		ra = a;
		repeat (2) @(posedge clk);
		#1 chk(rd, e);
	endtask
	task t_inc_plain();
		go('{{6'h0F, 1'b0, 7'h05}, {4'hC, 2'h0, 8'h77},
			14'h0000, 14'h0000, 14'h0000,
			14'h0000, 14'h0000, 14'h0000});
		fwr(7'h05, 8'h41);
		sync();
		step(8'h42, 1'b0, 1'b0);
		step(8'h77, 1'b0, 1'b0);
	endtask
	// zero sums squash the next word, both destinations
	task t_inc_skip();
		go('{{6'h38, 8'h00}, {6'h0F, 1'b1, 7'h06},
			{4'hC, 2'h0, 8'h11}, {4'hC, 2'h0, 8'h22},
			{6'h0F, 1'b0, 7'h09}, {4'hC, 2'h0, 8'h33},
			{4'hC, 2'h0, 8'h44}, 14'h0000});
		fwr(7'h06, 8'hFF);
		fwr(7'h09, 8'hFF);
		sync();
		step(8'h00, 1'b1, 1'b0);
		step(8'h00, 1'b1, 1'b0);
		step(8'h00, 1'b1, 1'b1);
		step(8'h22, 1'b1, 1'b0);
		step(8'h00, 1'b1, 1'b0);
		step(8'h00, 1'b1, 1'b1);
		step(8'h44, 1'b1, 1'b0);
		rdchk(7'h06, 8'h00);
	endtask
	task t_or_file();
		go('{{4'hC, 2'h0, 8'h91}, {6'h04, 1'b0, 7'h07},
			{6'h04, 1'b1, 7'h07}, {4'hC, 2'h0, 8'h00},
			{6'h04, 1'b0, 7'h08}, 14'h0000, 14'h0000, 14'h0000});
		fwr(7'h07, 8'h13);
		fwr(7'h08, 8'h00);
		sync();
		step(8'h91, 1'b0, 1'b0);
		step(8'h93, 1'b0, 1'b0);
		step(8'h93, 1'b0, 1'b0);
		step(8'h00, 1'b0, 1'b0);
		step(8'h00, 1'b1, 1'b0);
		rdchk(7'h07, 8'h93);
	endtask
	// every value of the ignored load bits, then a foreign word
	task t_or_lit();
		go('{{4'hC, 2'h0, 8'h9A}, {6'h38, 8'h35},
			{4'hC, 2'h0, 8'h00}, {6'h38, 8'h00},
			{4'hC, 2'h1, 8'h5A}, {4'hC, 2'h2, 8'hA5},
			{4'hC, 2'h3, 8'h00}, 14'h3FFF});
		sync();
		step(8'h9A, 1'b0, 1'b0);
		step(8'hBF, 1'b0, 1'b0);
		step(8'h00, 1'b0, 1'b0);
		step(8'h00, 1'b1, 1'b0);
		step(8'h5A, 1'b1, 1'b0);
		step(8'hA5, 1'b1, 1'b0);
		step(8'h00, 1'b1, 1'b0);
		step(8'h00, 1'b1, 1'b1);
	endtask
	initial begin
		t_inc_plain();
		t_inc_skip();
		t_or_file();
		t_or_lit();
		results();
	end
	// about 160 cycles expected; cut a hang well beyond that
	initial begin
		#20000;
		failures++;
		results();
	end
endmodule
`default_nettype wire
